/* File: video_peak_pit_capture_tb_top.sv */
/*
 video_peak_pit_capture_tb_top: self-checking bench for vpc_top.
 Assumes the host model as APB master and full-size capture memory.
*/
`timescale 1ns/100ps
module video_peak_pit_capture_tb_top;
	import vpc_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [7:0] code = 8'h00;
	logic over = 1'b0;
	logic under = 1'b0;
	logic phase = 1'b0;
	logic gain, psel, pen, pwr, prdy, perr;
	logic [7:0] paddr;
	logic [31:0] pwd, prd;
	int fail_count = 0;
	int samples_checked = 0;
	int cyc = 0;

	// ****************************************
	// clock, reset, watchdog
	// ****************************************
	always #2 clk = ~clk;
	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
	end
	// ceiling well above the expected run of under a thousand cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			conclude();
		end
	end

	vpc_top uut (.i_clk(clk), .i_ce(1'b1), .i_arst_n(arst_n), .i_adc_code(code),
		.i_adc_over(over), .i_adc_under(under), .i_bucket_phase(phase),
		.o_double_gain_select(gain), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwd), .o_pready(prdy), .o_pslverr(perr),
		.o_prdata(prd));
	vpc_apb_host host (.i_clk(clk), .i_pready(prdy), .i_pslverr(perr), .i_prdata(prd),
		.o_psel(psel), .o_penable(pen), .o_pwrite(pwr), .o_paddr(paddr), .o_pwdata(pwd));

	// ****************************************
	// helpers
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			fail_count++;
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
		logic [31:0] d;
		logic e;
		host.xfer(1'b0, a, WORD_ZERO, d, e);
		chk(d, exp);
		chk({31'h0, e}, {31'h0, eerr});
	endtask
	task automatic get(input logic [7:0] a, output logic [31:0] d);
		logic e;
		host.xfer(1'b0, a, WORD_ZERO, d, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic eerr);
		logic [31:0] d;
		logic e;
		host.xfer(1'b1, a, v, d, e);
		chk({31'h0, e}, {31'h0, eerr});
	endtask
	// raise phase until the write pointer moves, so it spans one tick only
	task automatic bucket_start();
		logic [31:0] w0, w1;
		int n;
		get(REG_WADDR, w0);
		@(posedge clk);
		phase <= 1'b1;
		for (n = 0; n < 60; n++) begin
			get(REG_WADDR, w1);
			if (w1 !== w0) break;
		end
		phase <= 1'b0;
		chk({31'h0, w1 !== w0}, 32'h1);
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_regs();
		rd(REG_CTRL, 32'h0000_0008, 1'b0);
		chk({31'h0, gain}, 32'h0);
		wr(REG_CTRL, 32'h0000_000a, 1'b0);
		#1 chk({31'h0, gain}, 32'h1);
		wr(REG_CTRL, 32'h0000_0008, 1'b0);
		rd(8'h20, WORD_ZERO, 1'b1);
		wr(REG_STATUS, 32'h0000_0001, 1'b1);
	endtask
	// full rate stores every sample; pins saturate the code
	task automatic t_rate(input logic ov, input logic [31:0] exp);
		logic [31:0] n;
		@(posedge clk);
		over <= ov;
		under <= ~ov;
		code <= 8'h77;
		wr(REG_CTRL, 32'h0000_000d, 1'b0);
		repeat (60) @(posedge clk);
		rd(REG_RDATA, WORD_ZERO, 1'b1);
		wr(REG_CTRL, 32'h0000_000c, 1'b0);
		get(REG_WADDR, n);
		wr(REG_RADDR, n - 32'h1, 1'b0);
		rd(REG_RDATA, exp, 1'b0);
		@(posedge clk);
		over <= 1'b0;
		under <= 1'b0;
	endtask
	// one bucket of 40, 90, 20, 60 under a given detector mode
	task automatic t_mode(input logic [31:0] ctl, input logic [31:0] exv, input logic [31:0] exs);
		logic [31:0] w;
		@(posedge clk);
		code <= 8'h28;
		wr(REG_CTRL, ctl, 1'b0);
		bucket_start();
		@(posedge clk);
		code <= 8'h5a;
		repeat (50) @(posedge clk);
		code <= 8'h14;
		repeat (50) @(posedge clk);
		code <= 8'h3c;
		repeat (50) @(posedge clk);
		rd(REG_STATUS, exs, 1'b0);
		get(REG_WADDR, w);
		bucket_start();
		wr(REG_CTRL, ctl & 32'h1e, 1'b0);
		wr(REG_RADDR, w, 1'b0);
		rd(REG_RDATA, exv, 1'b0);
	endtask

	task automatic conclude();
		$display("checks=%0d errors=%0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		@(posedge arst_n);
		t_regs();
		t_rate(1'b1, 32'h0000_00ff);
		t_rate(1'b0, 32'h0000_0000);
		t_mode(32'h0000_0009, 32'h0000_005a, 32'h0000_065a);
		t_mode(32'h0000_0019, 32'h0000_0014, 32'h0000_0514);
		t_mode(32'h0000_0001, 32'h0000_003c, 32'h0000_003c);
		conclude();
	end
endmodule // video_peak_pit_capture_tb_top

/* File: vpc_apb_host.sv */
/*
 vpc_apb_host: controller processor model, an APB master reaching the capture block.
 Assumes the bench calls xfer from one process only.
*/
`timescale 1ns/100ps
module vpc_apb_host (
	// bus clock
	input wire logic i_clk,
	// slave answer
	input wire logic i_pready,
	input wire logic i_pslverr,
	input wire logic [31:0] i_prdata,
	// request
	output logic o_psel,
	output logic o_penable,
	output logic o_pwrite,
	output logic [7:0] o_paddr,
	output logic [31:0] o_pwdata
);
	// ****************************************
	// idle bus at time zero
	// ****************************************
	initial begin
		o_psel = 1'b0;
		o_penable = 1'b0;
		o_pwrite = 1'b0;
		o_paddr = 8'h00;
		o_pwdata = 32'h0000_0000;
	end

	// one transfer; capture memory is only read with write mode off
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		begin
			@(posedge i_clk);
			o_psel <= 1'b1;
			o_pwrite <= wr;
			o_paddr <= addr;
			o_pwdata <= wd;
			@(posedge i_clk);
			o_penable <= 1'b1;
			// no cycle count assumed; only the bench watchdog ends a dead wait
			do begin
				@(posedge i_clk);
			end while (i_pready !== 1'b1);
			rd = i_prdata;
			err = i_pslverr;
			o_psel <= 1'b0;
			o_penable <= 1'b0;
		end
	endtask
endmodule // vpc_apb_host

/* File: vpc_cmp.sv */
/*
 vpc_cmp: 8-bit magnitude comparator between the new sample and the held value.
 Assumes both operands come from flops on the same clock.
*/
`timescale 1ns/100ps
module vpc_cmp import vpc_pkg::*; #(
	parameter int W = CODE_W
) (
	// operands
	input wire logic [W-1:0] i_new,
	input wire logic [W-1:0] i_held,
	// result
	output vpc_cmp_t o_cmp
);
	// equal codes raise neither flag
	always_comb begin
		o_cmp.new_above_held = (i_new > i_held);
		o_cmp.new_below_held = (i_new < i_held);
	end

	cmp_excl_a: assert final (!(o_cmp.new_above_held && o_cmp.new_below_held) &&
		((i_new == i_held) == !(o_cmp.new_above_held || o_cmp.new_below_held)))
		else $error("comparator flags inconsistent");
endmodule // vpc_cmp

/* File: vpc_pkg.sv */
/*
 vpc_pkg: constants, register map and carriers for the video peak/pit capture block.
 Assumes a 250 MHz system clock and an APB master with 32-bit data.
*/
// What this block does
// - converter codes are unsigned 8-bit, taken at a fixed twelve million per second.
// - codes saturate at 255 above full scale and at zero below zero.
// - peak or pit detection only applies below the full 12 MHz rate.
// - peak mode stores the largest code seen in each bucket.
// - pit mode stores the smallest code seen in each bucket.
// - sample mode stores the last code taken in each bucket.
// - hold latch loads on the sample tick when inhibit is low, else keeps.
// - full-rate select forces inhibit low so every sample is latched, and stored in write mode.
// - comparator flags above when new exceeds held, below when smaller, none when equal.
// - below full rate, peak/pit latch keeps the bucket extreme from phase, polarity, flags.
// - capture RAM is written only in write mode and readable only outside it.
// - below full rate the hold latch output is the capture RAM write data; full rate writes the sample.
// - capture memory holds 32 K bytes, one byte per stored sample.
// - double gain select picks the times-two path when high, unity when low.
package vpc_pkg;
	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_MHZ = 250;
	localparam int SAMPLE_MHZ = 12;
	localparam logic [8:0] ACC_STEP = 9'(SAMPLE_MHZ);
	localparam logic [8:0] ACC_WRAP = 9'(CLK_MHZ);
	// ****************************************
	// sizes
	// ****************************************
	localparam int CODE_W = 8;
	localparam int RAM_BYTES = 32768;
	localparam int ADDR_W = $clog2(RAM_BYTES);
	localparam logic [CODE_W-1:0] CODE_MAX = 8'hff;
	localparam logic [CODE_W-1:0] CODE_MIN = 8'h00;
	// ****************************************
	// register byte addresses
	// ****************************************
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_RADDR = 8'h08;
	localparam logic [7:0] REG_RDATA = 8'h0c;
	localparam logic [7:0] REG_WADDR = 8'h10;
	// ctrl field positions
	localparam int CTRL_WRITE = 0;
	localparam int CTRL_GAIN = 1;
	localparam int CTRL_FULL = 2;
	localparam int CTRL_SAMP_N = 3;
	localparam int CTRL_PIT = 4;
	localparam int CTRL_W = 5;
	// status field positions
	localparam int ST_ABOVE = 8;
	localparam int ST_BELOW = 9;
	localparam int ST_INH_N = 10;
	// ctrl reset: idle, unity gain, sample mode off, peak polarity
	localparam logic [CTRL_W-1:0] CTRL_RST = 5'h08;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic pit_select;
		logic sample_mode_n;
		logic full_rate_select;
		logic double_gain_select;
		logic write_mode;
	} vpc_ctrl_t;

	typedef struct packed {
		logic new_above_held;
		logic new_below_held;
	} vpc_cmp_t;
endpackage

/* File: vpc_ram.sv */
/*
 vpc_ram: capture memory, one byte per stored detected sample.
 Assumes one write port from the detector and one read port for the processor.
*/
`timescale 1ns/100ps
module vpc_ram import vpc_pkg::*; #(
	parameter int DEPTH = RAM_BYTES,
	parameter int AW = ADDR_W
) (
	// clock
	input wire logic i_clk,
	input wire logic i_ce,
	// write port
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [CODE_W-1:0] i_wdata,
	// read port
	input wire logic [AW-1:0] i_raddr,
	output logic [CODE_W-1:0] o_rdata
);
	logic [CODE_W-1:0] mem [DEPTH];

	// no reset on the array: contents are undefined until written
	always_ff @(posedge i_clk) begin
		if (i_ce && i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// read is asynchronous so the bus slave can register it in the setup cycle
	assign o_rdata = mem[i_raddr];
endmodule // vpc_ram

/* File: vpc_top.sv */
/*
 vpc_top: detection path of a fast video digitizer with APB register access.
 Assumes converter code, range flags and bucket phase arrive as pins outside
 the clock domain; the processor reads capture memory only with write mode off.
*/
`timescale 1ns/100ps
module vpc_top import vpc_pkg::*; #(
	parameter int DEPTH = RAM_BYTES,
	parameter int AW = ADDR_W
) (
	// clock, enable and reset
	input wire logic i_clk,
	input wire logic i_ce,
	input wire logic i_arst_n,
	// converter pins
	input wire logic [CODE_W-1:0] i_adc_code,
	input wire logic i_adc_over,
	input wire logic i_adc_under,
	input wire logic i_bucket_phase,
	// analog steering
	output logic o_double_gain_select,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [7:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic [31:0] o_prdata
);
	// ****************************************
	// declarations
	// ****************************************
	vpc_ctrl_t ctrl_r;
	vpc_cmp_t cmp;
	logic [CODE_W-1:0] code_s1_r, code_s2_r, code_s3_r, code_r;
	logic [2:0] over_s_r, under_s_r, phase_s_r;
	logic over_r, under_r, phase_r;
	logic [8:0] acc_r;
	logic tick;
	logic [CODE_W-1:0] sample;
	logic [CODE_W-1:0] held_r;
	logic hold_load_inhibit_n;
	logic ram_we;
	logic [CODE_W-1:0] ram_wdata, ram_rdata;
	logic [AW-1:0] waddr_r, raddr_r;
	logic setup, acc_done, wr_acc, rd_acc;
	logic [31:0] rd_mux;
	logic err_nxt, err_r;

	// returns true when the address names a mapped register
	function automatic logic reg_hit(input logic [7:0] a);
		return (a == REG_CTRL) || (a == REG_STATUS) || (a == REG_RADDR) ||
			(a == REG_RDATA) || (a == REG_WADDR);
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	// three stages; a new value counts only once stages two and three agree
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			code_s1_r <= CODE_MIN;
			code_s2_r <= CODE_MIN;
			code_s3_r <= CODE_MIN;
			over_s_r <= 3'h0;
			under_s_r <= 3'h0;
			phase_s_r <= 3'h0;
		end else if (i_ce) begin
			code_s1_r <= i_adc_code;
			code_s2_r <= code_s1_r;
			code_s3_r <= code_s2_r;
			over_s_r <= {over_s_r[1:0], i_adc_over};
			under_s_r <= {under_s_r[1:0], i_adc_under};
			phase_s_r <= {phase_s_r[1:0], i_bucket_phase};
		end
	end

	// accepted values; a bus in mid-change keeps the last stable code
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			code_r <= CODE_MIN;
			over_r <= 1'b0;
			under_r <= 1'b0;
			phase_r <= 1'b0;
		end else if (i_ce) begin
			if (code_s2_r == code_s3_r) begin
				code_r <= code_s3_r;
			end
			if (over_s_r[1] == over_s_r[2]) begin
				over_r <= over_s_r[2];
			end
			if (under_s_r[1] == under_s_r[2]) begin
				under_r <= under_s_r[2];
			end
			if (phase_s_r[1] == phase_s_r[2]) begin
				phase_r <= phase_s_r[2];
			end
		end
	end

	// ****************************************
	// sample clock
	// ****************************************
	// fractional accumulator: exactly 12 ticks per 250 clocks on average,
	// so tick spacing is 21 cycles, shortened to 20 twice in every 250
	assign tick = i_ce && ((acc_r + ACC_STEP) >= ACC_WRAP);

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			acc_r <= 9'h000;
		end else if (i_ce) begin
			acc_r <= tick ? 9'(acc_r + ACC_STEP - ACC_WRAP) : 9'(acc_r + ACC_STEP);
		end
	end

	// saturate out-of-range input to the end codes
	always_comb begin
		if (over_r) begin
			sample = CODE_MAX;
		end else if (under_r) begin
			sample = CODE_MIN;
		end else begin
			sample = code_r;
		end
	end

	// ****************************************
	// detector
	// ****************************************
	vpc_cmp #(
		.W(CODE_W)
	) u_cmp (
		.i_new(sample),
		.i_held(held_r),
		.o_cmp(cmp)
	);

	// load decision; in peak or pit mode equal samples never reload, keeping the first extreme
	always_comb begin
		if (ctrl_r.full_rate_select) begin
			hold_load_inhibit_n = 1'b0;
		end else if (!ctrl_r.sample_mode_n) begin
			hold_load_inhibit_n = 1'b0;
		end else if (phase_r) begin
			hold_load_inhibit_n = 1'b0;
		end else if (ctrl_r.pit_select) begin
			hold_load_inhibit_n = !cmp.new_below_held;
		end else begin
			hold_load_inhibit_n = !cmp.new_above_held;
		end
	end

	// hold latch
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			held_r <= CODE_MIN;
		end else if (tick && !hold_load_inhibit_n) begin
			held_r <= sample;
		end
	end

	// store the finished bucket at its boundary, or every sample at full rate;
	// at full rate the latch loads this very sample, so store what it takes
	assign ram_we = tick && ctrl_r.write_mode && (ctrl_r.full_rate_select || phase_r);
	assign ram_wdata = ctrl_r.full_rate_select ? sample : held_r;

	// circular write address
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			waddr_r <= '0;
		end else if (ram_we) begin
			waddr_r <= AW'(waddr_r + 1'b1);
		end
	end

	vpc_ram #(
		.DEPTH(DEPTH),
		.AW(AW)
	) u_ram (
		.i_clk(i_clk),
		.i_ce(i_ce),
		.i_we(ram_we),
		.i_waddr(waddr_r),
		.i_wdata(ram_wdata),
		.i_raddr(raddr_r),
		.o_rdata(ram_rdata)
	);

	// ****************************************
	// apb slave
	// ****************************************
	// one wait-free access: data is registered in setup, answered in access
	assign setup = i_ce && i_psel && !i_penable;
	assign acc_done = i_ce && i_psel && i_penable;
	assign wr_acc = acc_done && i_pwrite && !err_r;
	assign rd_acc = acc_done && !i_pwrite && !err_r;
	assign o_pready = acc_done; // no answer while the enable holds the block frozen
	assign o_pslverr = o_pready && err_r;

	// memory data is refused while capture owns the RAM
	always_comb begin
		err_nxt = !reg_hit(i_paddr) ||
			((i_paddr == REG_RDATA) && ctrl_r.write_mode) ||
			(i_pwrite && ((i_paddr == REG_STATUS) || (i_paddr == REG_RDATA) ||
			(i_paddr == REG_WADDR)));
		rd_mux = WORD_ZERO;
		unique case (i_paddr)
			REG_CTRL: rd_mux[CTRL_W-1:0] = ctrl_r;
			REG_STATUS: begin
				rd_mux[CODE_W-1:0] = held_r;
				rd_mux[ST_ABOVE] = cmp.new_above_held;
				rd_mux[ST_BELOW] = cmp.new_below_held;
				rd_mux[ST_INH_N] = hold_load_inhibit_n;
			end
			REG_RADDR: rd_mux[AW-1:0] = raddr_r;
			REG_RDATA: rd_mux[CODE_W-1:0] = ctrl_r.write_mode ? CODE_MIN : ram_rdata;
			REG_WADDR: rd_mux[AW-1:0] = waddr_r;
			default: rd_mux = WORD_ZERO;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_prdata <= WORD_ZERO;
			err_r <= 1'b0;
		end else if (setup) begin
			o_prdata <= (i_pwrite || err_nxt) ? WORD_ZERO : rd_mux;
			err_r <= err_nxt;
		end
	end

	// control word
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_acc && (i_paddr == REG_CTRL)) begin
			ctrl_r <= i_pwdata[CTRL_W-1:0];
		end
	end

	assign o_double_gain_select = ctrl_r.double_gain_select;

	// read pointer: software loads it, each accepted data read steps it on
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			raddr_r <= '0;
		end else if (wr_acc && (i_paddr == REG_RADDR)) begin
			raddr_r <= i_pwdata[AW-1:0];
		end else if (rd_acc && (i_paddr == REG_RDATA)) begin
			raddr_r <= AW'(raddr_r + 1'b1);
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sequence peak_skip_s;
		tick && !ctrl_r.full_rate_select && ctrl_r.sample_mode_n && !phase_r;
	endsequence

	full_rate_load_a: assert property (tick && ctrl_r.full_rate_select |=>
		held_r == $past(sample)) else $error("full rate sample not latched");
	bucket_restart_a: assert property (tick && phase_r |=> held_r == $past(sample))
		else $error("bucket start did not reload");
	peak_keep_a: assert property (peak_skip_s ##0 (!ctrl_r.pit_select &&
		sample <= held_r) |=> $stable(held_r)) else $error("peak latch took a lower code");
	pit_keep_a: assert property (peak_skip_s ##0 (ctrl_r.pit_select &&
		sample >= held_r) |=> $stable(held_r)) else $error("pit latch took a higher code");
	peak_take_a: assert property (peak_skip_s ##0 (!ctrl_r.pit_select &&
		sample > held_r) |=> held_r == $past(sample)) else $error("peak not taken");
	pit_take_a: assert property (peak_skip_s ##0 (ctrl_r.pit_select &&
		sample < held_r) |=> held_r == $past(sample)) else $error("pit not taken");
	sample_track_a: assert property (tick && !ctrl_r.sample_mode_n |=>
		held_r == $past(sample)) else $error("sample mode did not track");
	no_load_a: assert property (!tick |=> $stable(held_r))
		else $error("latch moved without a sample tick");
	ram_write_a: assert property (ram_we |-> ctrl_r.write_mode &&
		ram_wdata == (ctrl_r.full_rate_select ? sample : held_r))
		else $error("memory written outside write mode");
	tick_space_a: assert property (tick |=> !tick [*8])
		else $error("sample ticks too close");
	sat_high_a: assert property (over_r |-> sample == CODE_MAX)
		else $error("over range not saturated");
	gain_write_a: assert property (wr_acc && i_paddr == REG_CTRL |=>
		o_double_gain_select == $past(i_pwdata[CTRL_GAIN])) else $error("gain not updated");
	// guards on saturation, loading, flags, storage and refusal
	sat_low_a: assert property (under_r && !over_r |-> sample == CODE_MIN)
		else $error("under range not saturated");
	inh_full_a: assert property (ctrl_r.full_rate_select |->
		!hold_load_inhibit_n) else $error("full rate did not force loading");
	inh_sample_a: assert property (!ctrl_r.sample_mode_n |->
		!hold_load_inhibit_n) else $error("sample mode did not force loading");
	above_flag_a: assert property (cmp.new_above_held |-> sample > held_r)
		else $error("above flag without a larger sample");
	store_idle_a: assert property (!ctrl_r.write_mode |=> $stable(waddr_r))
		else $error("write pointer moved outside write mode");
	rdata_guard_a: assert property (rd_acc && i_paddr == REG_RDATA |->
		!ctrl_r.write_mode) else $error("memory read during write mode");
	refuse_zero_a: assert property (o_pslverr |-> o_prdata == WORD_ZERO)
		else $error("refused transfer returned data");
endmodule // vpc_top
